// ==== cfg_fifo.v ====
// Small synchronous FIFO with valid and ready on both sides
module cfg_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire             clk_sys_i,
  input  wire             reset_n_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;

  wire do_push;
  wire do_pop;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign do_push     = in_valid_i & in_ready_o;
  assign do_pop      = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i) begin
    if (do_push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push & ~do_pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (do_pop & ~do_push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule

// ==== cfg_host_model.sv ====
// Behavioural configuration host driving the link pins
module cfg_host_model (
  input  wire logic       clk_sys_i,
  input  wire logic       busy_i,
  output logic            config_clock_o,
  output logic            ce_n_o,
  output logic            din_o,
  output logic [7:1]      data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    config_clock_o = 1'b0;
    ce_n_o = 1'b1;
    din_o = 1'b1;
    data_o = 7'h55;
  end
  ////////////////////////////////////////
  // One link period; clock idles low between calls
  task edge_out(input logic d0, input logic [7:1] dh);
    din_o <= d0;
    data_o <= dh;
    repeat (16) @(posedge clk_sys_i);
    config_clock_o <= 1'b1;
    repeat (16) @(posedge clk_sys_i);
    config_clock_o <= 1'b0;
  endtask
  task serial_frame(input logic [31:0] w, input logic stop);
    int i;
    edge_out(1'b0, data_o);
    for (i = 0; i < 32; i++)
      edge_out(w[i], data_o);
    edge_out(stop, data_o);
    edge_out(stop, data_o);
    din_o <= 1'b1;
  endtask
  // A compliant host waits out busy; a rude one does not
  task par_byte(input logic [7:0] b, input logic polite);
    ce_n_o <= 1'b0;
    @(posedge clk_sys_i);
    while (polite && busy_i)
      @(posedge clk_sys_i);
    edge_out(b[0], b[7:1]);
  endtask
  task deselect;
    ce_n_o <= 1'b1;
    data_o <= ~data_o;
    din_o <= ~din_o;
  endtask
endmodule

// ==== cfg_port_regs.vh ====
// Constants for the configuration port front end
// Operation
// - Each logic_tile column holds 48 frames
// - Transfers move whole frames only
// - Parallel bus sampled only while chip enable low
// - Chip enable high ignores every clock edge (chip enable gates edges in parallel mode only; serial bits are still taken)
// - Serial bit captured on rising config_clock
// - Serial input pin is parallel_bit0
// - Master serial chain output lags 1.5 periods
// - Serial modes drive chain output downstream
// - Shared pin: chain output or wait handshake
// - Busy high at edge rejects bus data
// - Completion pin signals configuration finished
// - External low completion pin holds startup
// - Serial input released after configuration
// - Serial frames framed by start, stop bits
// - Clock driven by device only in master
// - Error pin pulled low on data error
`ifndef CFG_PORT_REGS_VH
`define CFG_PORT_REGS_VH

// Mode strap encodings and strap settle count
`define MODE_SLAVE_SERIAL  2'h0
`define MODE_MASTER_SERIAL 2'h1
`define MODE_PARALLEL      2'h2
`define MODE_SETTLE        2'h2

// Frame geometry
`define FRAMES_PER_COLUMN  8'h30
`define COLUMN_COUNT       8'h02
`define BYTES_PER_FRAME    2'h3
`define FRAME_LAST_BIT     5'h1f
`define BYTE_LAST_BIT      3'h7
`define STOP_BITS_LAST     2'h1

// Master clock divider: 16 cycles of 5 ns per half period
`define MASTER_HALF_NS     80
`define SYS_PERIOD_NS      5
`define MASTER_HALF_CYC    5'h10

// Buffer shape
`define FIFO_WIDTH         9
`define FIFO_DEPTH         4
`define FIFO_AW            2

`endif

// ==== fpga_config_port_frontend.v ====
// Configuration port front end: serial and parallel loading, chaining, completion
`include "cfg_port_regs.vh"

module fpga_config_port_frontend (
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire [1:0] mode_i,
  input  wire       config_clock_i,
  output reg        config_clock_o,
  output reg        config_clock_oe_o,
  input  wire       chip_enable_n_i,
  input  wire       serial_din_i,
  input  wire [7:1] parallel_data_i,
  output reg        dout_busy_o,
  input  wire       done_i,
  output reg        done_o,
  output reg        done_oe_o,
  output reg        error_n_o,
  output reg        error_n_oe_o,
  input  wire       hold_on_done_i,
  output reg        startup_release_o,
  output reg        din_user_en_o,
  output reg [7:0]  frame_data_o,
  output reg        frame_last_o,
  output reg        frame_valid_o,
  input  wire       frame_ready_i
);

  localparam ST_LOAD = 4'b0001;
  localparam ST_WAIT = 4'b0010;
  localparam ST_RUN  = 4'b0100;
  localparam ST_ERR  = 4'b1000;

  localparam SB_IDLE = 3'b001;
  localparam SB_DATA = 3'b010;
  localparam SB_STOP = 3'b100;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg       config_clock_s1;
  reg       config_clock_s2;
  reg       config_clock_d;
  reg       csn_s1;
  reg       csn_s2;
  reg       din_s1;
  reg       din_s2;
  reg [7:1] pdat_s1;
  reg [7:1] pdat_s2;
  reg       done_s1;
  reg       done_s2;
  reg [1:0] mode_s1;
  reg [1:0] mode_s2;
  reg       hold_s1;
  reg       hold_s2;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      config_clock_s1 <= 1'b0;
      config_clock_s2 <= 1'b0;
      config_clock_d  <= 1'b0;
      csn_s1  <= 1'b1;
      csn_s2  <= 1'b1;
      din_s1  <= 1'b1;
      din_s2  <= 1'b1;
      pdat_s1 <= 7'h00;
      pdat_s2 <= 7'h00;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      mode_s1 <= 2'h0;
      mode_s2 <= 2'h0;
      hold_s1 <= 1'b0;
      hold_s2 <= 1'b0;
    end else begin
      config_clock_s1 <= config_clock_i;
      config_clock_s2 <= config_clock_s1;
      config_clock_d  <= config_clock_s2;
      csn_s1  <= chip_enable_n_i;
      csn_s2  <= csn_s1;
      din_s1  <= serial_din_i;
      din_s2  <= din_s1;
      pdat_s1 <= parallel_data_i;
      pdat_s2 <= pdat_s1;
      done_s1 <= done_i;
      done_s2 <= done_s1;
      mode_s1 <= mode_i;
      mode_s2 <= mode_s1;
      hold_s1 <= hold_on_done_i;
      hold_s2 <= hold_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode strap, caught once both synchroniser stages hold it
  reg [1:0] mode;
  reg [1:0] mode_age;
  reg       mode_taken;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode       <= `MODE_SLAVE_SERIAL;
      mode_age   <= 2'h0;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      mode_age   <= mode_age + 2'h1;
      mode       <= mode_s2;
      mode_taken <= (mode_age == `MODE_SETTLE);
    end
  end

  wire is_master   = mode_taken & (mode == `MODE_MASTER_SERIAL);
  wire is_parallel = mode_taken & (mode == `MODE_PARALLEL);
  wire is_serial   = mode_taken & ~is_parallel;

  ////////////////////////////////////////////////////////////////////////
  // Clock source: divider in master mode, sampled pin otherwise
  reg [4:0] div_cnt;
  reg       master_rise;
  reg [3:0] state;

  wire loading = (state == ST_LOAD);

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt           <= 5'h00;
      config_clock_o    <= 1'b0;
      config_clock_oe_o <= 1'b0;
      master_rise       <= 1'b0;
    end else begin
      config_clock_oe_o <= is_master & loading;
      master_rise       <= 1'b0;
      if (is_master & loading) begin
        if (div_cnt == `MASTER_HALF_CYC - 5'h01) begin
          div_cnt        <= 5'h00;
          config_clock_o <= ~config_clock_o;
          master_rise    <= ~config_clock_o;
        end else begin
          div_cnt <= div_cnt + 5'h01;
        end
      end else begin
        div_cnt        <= 5'h00;
        config_clock_o <= 1'b0;
      end
    end
  end

  wire pin_rise  = config_clock_s2 & ~config_clock_d;
  wire clk_rise  = is_master ? master_rise : pin_rise;
  wire bit_edge  = is_serial & loading & clk_rise;
  // Chip enable gates every edge in parallel mode only
  wire par_edge  = is_parallel & loading & pin_rise & ~csn_s2;

  ////////////////////////////////////////////////////////////////////////
  // Buffer between the pins and the frame sink
  reg        push_valid;
  reg [8:0]  push_data;
  wire       fifo_in_ready;
  wire       fifo_out_valid;
  wire [8:0] fifo_out_data;
  wire       fifo_out_ready = ~frame_valid_o | frame_ready_i;

  cfg_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      frame_valid_o <= 1'b0;
      frame_data_o  <= 8'h00;
      frame_last_o  <= 1'b0;
    end else if (fifo_out_ready) begin
      frame_valid_o <= fifo_out_valid;
      frame_data_o  <= fifo_out_data[7:0];
      frame_last_o  <= fifo_out_data[8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial deframer and chain output
  reg [2:0] sb_state;
  reg [4:0] bit_cnt;
  reg [1:0] stop_cnt;
  reg [7:0] shift;
  reg       din_held;
  reg       dout_bit;
  reg       ser_err;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sb_state <= SB_IDLE;
      bit_cnt  <= 5'h00;
      stop_cnt <= 2'h0;
      shift    <= 8'h00;
      din_held <= 1'b1;
      dout_bit <= 1'b1;
      ser_err  <= 1'b0;
    end else begin
      ser_err <= 1'b0;
      if (bit_edge) begin
        // Output updates one edge after capture, 1.5 periods after arrival
        din_held <= din_s2;
        dout_bit <= din_held;
        case (sb_state)
          SB_IDLE: begin
            if (!din_s2) begin
              sb_state <= SB_DATA;
              bit_cnt  <= 5'h00;
            end
          end
          SB_DATA: begin
            shift   <= {din_s2, shift[7:1]};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `FRAME_LAST_BIT) begin
              sb_state <= SB_STOP;
              stop_cnt <= 2'h0;
            end
          end
          SB_STOP: begin
            if (!din_s2) begin
              ser_err <= 1'b1;
            end
            stop_cnt <= stop_cnt + 2'h1;
            if (stop_cnt == `STOP_BITS_LAST) begin
              sb_state <= SB_IDLE;
            end
          end
          default: begin
            sb_state <= SB_IDLE;
          end
        endcase
      end
    end
  end

  wire ser_byte_done = bit_edge & (sb_state == SB_DATA) & (bit_cnt[2:0] == `BYTE_LAST_BIT);

  ////////////////////////////////////////////////////////////////////////
  // Byte push, frame counting and sequencing
  reg [1:0] byte_cnt;
  reg [7:0] frame_cnt;
  reg [7:0] col_cnt;
  reg       busy;

  wire par_take  = par_edge & ~busy;
  wire take_last = ser_byte_done ? (bit_cnt == `FRAME_LAST_BIT) : (byte_cnt == `BYTES_PER_FRAME);
  wire take      = ser_byte_done | par_take;
  wire ovf_err   = ser_byte_done & ~fifo_in_ready;
  wire last_col  = (col_cnt == `COLUMN_COUNT - 8'h01);
  wire last_frm  = (frame_cnt == `FRAMES_PER_COLUMN - 8'h01);

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      push_valid <= 1'b0;
      push_data  <= 9'h000;
      byte_cnt   <= 2'h0;
      frame_cnt  <= 8'h00;
      col_cnt    <= 8'h00;
      state      <= ST_LOAD;
    end else begin
      push_valid <= 1'b0;
      case (state)
        ST_LOAD: begin
          if (ser_err | ovf_err) begin
            state <= ST_ERR;
          end else if (take) begin
            push_valid <= 1'b1;
            // Parallel mode uses the serial pin as parallel_bit0
            push_data  <= {take_last, ser_byte_done ? {din_s2, shift[7:1]} : {pdat_s2, din_s2}};
            byte_cnt   <= take_last ? 2'h0 : byte_cnt + 2'h1;
            if (take_last) begin
              // Frames count only when complete
              if (last_frm) begin
                frame_cnt <= 8'h00;
                col_cnt   <= col_cnt + 8'h01;
                if (last_col) begin
                  state <= ST_WAIT;
                end
              end else begin
                frame_cnt <= frame_cnt + 8'h01;
              end
            end
          end
        end
        ST_WAIT: begin
          if (!hold_s2 | done_s2) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          state <= ST_RUN;
        end
        ST_ERR: begin
          state <= ST_ERR;
        end
        default: begin
          state <= ST_ERR;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin outputs
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy              <= 1'b0;
      dout_busy_o       <= 1'b1;
      done_o            <= 1'b0;
      done_oe_o         <= 1'b1;
      error_n_o         <= 1'b0;
      error_n_oe_o      <= 1'b0;
      startup_release_o <= 1'b0;
      din_user_en_o     <= 1'b0;
    end else begin
      // Busy follows buffer space; the sink drains it, so it clears
      busy         <= is_parallel & loading & ~fifo_in_ready;
      dout_busy_o  <= is_parallel ? busy : dout_bit;
      done_o       <= 1'b0;
      done_oe_o    <= (state == ST_LOAD) | (state == ST_ERR);
      error_n_o    <= 1'b0;
      error_n_oe_o <= (state == ST_ERR);
      startup_release_o <= (state == ST_RUN);
      din_user_en_o     <= (state == ST_WAIT) | (state == ST_RUN);
    end
  end

endmodule

// ==== fpga_config_port_frontend_properties.sv ====
// Port-level assertions for the configuration port front end
`include "cfg_port_regs.vh"
module fpga_config_port_frontend_properties (
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  input wire logic [1:0] mode_i,
  input wire logic       config_clock_i,
  input wire logic       config_clock_o,
  input wire logic       config_clock_oe_o,
  input wire logic       dout_busy_o,
  input wire logic       done_i,
  input wire logic       done_oe_o,
  input wire logic       error_n_oe_o,
  input wire logic       hold_on_done_i,
  input wire logic       startup_release_o,
  input wire logic       din_user_en_o,
  input wire logic [7:0] frame_data_o,
  input wire logic       frame_last_o,
  input wire logic       frame_valid_o,
  input wire logic       frame_ready_i
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////
  sequence s_user_free;
    ##[0:2] din_user_en_o;
  endsequence
  sequence s_started;
    ##[1:3] startup_release_o;
  endsequence
  property p_stream_hold;
    frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_data_o) && $stable(frame_last_o);
  endproperty
  property p_error_sticky;
    error_n_oe_o |=> error_n_oe_o [*8];
  endproperty
  property p_error_no_done;
    error_n_oe_o |-> done_oe_o && !din_user_en_o;
  endproperty
  property p_user_free;
    $fell(done_oe_o) |-> s_user_free;
  endproperty
  property p_start_free;
    $fell(done_oe_o) && !hold_on_done_i |-> s_started;
  endproperty
  property p_start_hold;
    startup_release_o |-> !done_oe_o && (!hold_on_done_i || $past(done_i, 2));
  endproperty
  property p_clk_owner;
    config_clock_oe_o || config_clock_o |-> config_clock_oe_o && mode_i == `MODE_MASTER_SERIAL;
  endproperty
  // Chain output may only move just after a link clock rise
  property p_chain_edge;
    $changed(dout_busy_o) && mode_i == `MODE_SLAVE_SERIAL && $past(reset_n_i, 8)
      |-> config_clock_i && $past(config_clock_i, 2);
  endproperty
  property p_busy_bounded;
    mode_i == `MODE_PARALLEL && dout_busy_o && frame_ready_i && done_oe_o && !error_n_oe_o
      && $past(reset_n_i, 4) |-> ##[1:12] !dout_busy_o;
  endproperty
  a_stream_hold: assert property (p_stream_hold) else $error("stream word moved while stalled");
  a_error_sticky: assert property (p_error_sticky) else $error("error pin released");
  a_error_no_done: assert property (p_error_no_done) else $error("completion after error");
  a_user_free: assert property (p_user_free) else $error("input pin not released");
  a_start_free: assert property (p_start_free) else $error("startup not released");
  a_start_hold: assert property (p_start_hold) else $error("startup too early");
  a_clk_owner: assert property (p_clk_owner) else $error("clock driven outside master mode");
  a_chain_edge: assert property (p_chain_edge) else $error("chain output moved off edge");
  a_busy_bounded: assert property (p_busy_bounded) else $error("busy stuck high");
endmodule

// ==== fpga_config_port_frontend_test.sv ====
// Self-checking bench for the configuration port front end
`include "cfg_port_regs.vh"
module fpga_config_port_frontend_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys_i, reset_n_i, hold_on_done_i, frame_ready_i, done_hold;
  logic [1:0] mode_i;
  wire        host_clk, chip_enable_n_i, serial_din_i, config_clock_o, config_clock_oe_o, dout_busy_o;
  wire        done_o, done_oe_o, error_n_o, error_n_oe_o, startup_release_o, din_user_en_o;
  wire        frame_last_o, frame_valid_o;
  wire [7:1]  parallel_data_i;
  wire [7:0]  frame_data_o;
  wire        config_clock_i = config_clock_oe_o ? config_clock_o : host_clk;
  wire        done_i = !(done_oe_o || done_hold);
  int         failures, total_checks;
  logic [8:0] rxq[$], expq[$];
  logic       chain_on, chain_armed, bit_now, bit_prev;
  fpga_config_port_frontend dut_u (
    .clk_sys_i, .reset_n_i, .mode_i, .config_clock_i, .config_clock_o, .config_clock_oe_o,
    .chip_enable_n_i, .serial_din_i, .parallel_data_i, .dout_busy_o, .done_i, .done_o, .done_oe_o,
    .error_n_o, .error_n_oe_o, .hold_on_done_i, .startup_release_o, .din_user_en_o,
    .frame_data_o, .frame_last_o, .frame_valid_o, .frame_ready_i
  );
  cfg_host_model host_u (
    .clk_sys_i, .busy_i(dout_busy_o), .config_clock_o(host_clk), .ce_n_o(chip_enable_n_i),
    .din_o(serial_din_i), .data_o(parallel_data_i)
  );
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
    if (frame_valid_o && frame_ready_i)
      rxq.push_back({frame_last_o, frame_data_o});
  // Chain output is judged well after the synchroniser delay
  always @(posedge config_clock_i)
    if (chain_on) begin
      bit_now = serial_din_i;
      repeat (8) @(posedge clk_sys_i);
      if (chain_armed)
        check("chain", {8'h00, bit_prev}, {8'h00, dout_busy_o});
      bit_prev = bit_now;
      chain_armed = 1'b1;
    end
  ////////////////////////////////////////
  task check(input string what, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task expect_rx(input logic [8:0] e);
    repeat (8) @(posedge clk_sys_i);
    check("stream", e, rxq.size() ? rxq.pop_front() : ~e);
  endtask
  task do_reset(input logic [1:0] m, input logic h);
    reset_n_i <= 1'b0;
    mode_i <= m;
    hold_on_done_i <= h;
    rxq.delete();
    repeat (12) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
  endtask
  task send_par(input logic [7:0] k);
    host_u.par_byte(8'h5a + 8'h13 * k, 1'b1);
    expq.push_back({k[1:0] == 2'h3, 8'h5a + 8'h13 * k});
  endtask
  ////////////////////////////////////////
  task t_serial;
    do_reset(`MODE_SLAVE_SERIAL, 1'b0);
    chain_armed = 1'b0;
    chain_on = 1'b1;
    host_u.edge_out(1'b1, 7'h00);
    host_u.serial_frame(32'h3c5a96e1, 1'b1);
    chain_on = 1'b0;
    expect_rx(9'h0e1);
    expect_rx(9'h096);
    expect_rx(9'h05a);
    expect_rx(9'h13c);
    check("error pin", 9'h000, {8'h00, error_n_oe_o});
  endtask
  task t_error;
    do_reset(`MODE_SLAVE_SERIAL, 1'b0);
    host_u.serial_frame(32'h0000ffff, 1'b0);
    repeat (10) @(posedge clk_sys_i);
    check("error pin", 9'h001, {8'h00, error_n_oe_o});
    host_u.serial_frame(32'h12345678, 1'b1);
    check("error held", 9'h001, {8'h00, error_n_oe_o});
    check("error drive", 9'h000, {8'h00, error_n_o});
    check("done pin", 9'h001, {8'h00, done_oe_o});
    check("done drive", 9'h000, {8'h00, done_o});
  endtask
  task t_master;
    int n, first, per;
    logic prev;
    do_reset(`MODE_MASTER_SERIAL, 1'b0);
    prev = config_clock_o;
    first = -1;
    per = 0;
    for (n = 0; n < 200; n++) begin
      @(posedge clk_sys_i);
      if (config_clock_o && !prev && first >= 0 && per == 0)
        per = n - first;
      if (config_clock_o && !prev && first < 0)
        first = n;
      prev = config_clock_o;
    end
    check("clock period", 9'h020, per[8:0]);
    check("clock drive", 9'h001, {8'h00, config_clock_oe_o});
  endtask
  task t_parallel;
    logic [7:0] k;
    do_reset(`MODE_PARALLEL, 1'b0);
    frame_ready_i <= 1'b0;
    host_u.edge_out(1'b0, 7'h77);
    k = 8'h00;
    while (!dout_busy_o && k < 8'h08) begin
      send_par(k);
      k++;
    end
    check("buffer fill", 9'h001, {8'h00, k >= 8'h04});
    host_u.par_byte(8'hee, 1'b0);
    frame_ready_i <= 1'b1;
    for (; k < 8'h08; k++)
      send_par(k);
    host_u.deselect();
    while (expq.size())
      expect_rx(expq.pop_front());
  endtask
  task t_done(input logic h);
    int i;
    do_reset(`MODE_PARALLEL, h);
    done_hold <= h;
    for (i = 0; i < 383; i++)
      host_u.par_byte(i[7:0], 1'b1);
    check("done early", 9'h001, {8'h00, done_oe_o});
    host_u.par_byte(8'hff, 1'b1);
    repeat (12) @(posedge clk_sys_i);
    check("done pin", 9'h000, {8'h00, done_oe_o});
    check("din release", 9'h001, {8'h00, din_user_en_o});
    repeat (20) @(posedge clk_sys_i);
    check("startup held", {8'h00, !h}, {8'h00, startup_release_o});
    done_hold <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    check("startup", 9'h001, {8'h00, startup_release_o});
    host_u.deselect();
  endtask
  task summarize;
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    reset_n_i = 1'b0;
    mode_i = 2'h0;
    hold_on_done_i = 1'b0;
    frame_ready_i = 1'b1;
    done_hold = 1'b0;
    chain_on = 1'b0;
    t_serial();
    t_error();
    t_master();
    t_parallel();
    t_done(1'b0);
    t_done(1'b1);
    summarize();
  end
  initial begin
    #400000;
    failures++;
    summarize();
  end
endmodule
bind fpga_config_port_frontend fpga_config_port_frontend_properties chk_u (.*);
